// ### code_mem_pins_regs.vh
// Constants for the shared strap and code memory pin block
// Overview of operation
// - Pin two is clock source strap during reset
// - Release latches source strap, drops pull-down, drives address
// - Source 0 crystal 24MHz; 1 external clock
// - Pins one, zero are frequency strap during reset
// - Release latches frequency pair, drops pull-downs
// - Pair 00 is 24MHz, 11 is 48MHz
// - Source strap 1 floats pin two in sleep
// - Frequency bit 1 floats its pin in sleep
// - Source strap 0 drives pin two like upper pins
// - Frequency bit 0 drives its pin normally
// - Active-low write strobe marks write cycles
// - Active-low read strobe marks read cycles
// - Data bus used only when external code selected
// - Chip enable held high during chip reset
`ifndef CODE_MEM_PINS_REGS_VH
`define CODE_MEM_PINS_REGS_VH

// ==================================================
// Register offsets
`define CTRL_REG_OFFSET 8'h00
`define STATUS_REG_OFFSET 8'h04
`define STRAP_REG_OFFSET 8'h08

// ==================================================
// Control register fields
`define CTRL_IDLE_BIT 0
`define CTRL_SLEEP_BIT 1
`define CTRL_INT_CODE_BIT 2
`define CTRL_RESET_VALUE 3'h4

// ==================================================
// Status register fields
`define STAT_IN_RESET_BIT 0
`define STAT_SLEEP_COND_BIT 1
`define STAT_BUSY_BIT 2

// ==================================================
// Strap register fields
`define STRAP_SRC_BIT 0
`define STRAP_FREQ_LO 1
`define STRAP_EXT_CLK_BIT 3
`define STRAP_48M_BIT 4
`define STRAP_RSVD_BIT 5

// ==================================================
// Strap encodings
`define FREQ_24M 2'h0
`define FREQ_48M 2'h3

// ==================================================
// Timing
`define CLK_PERIOD_NS 10
`define STROBE_NS 30
`define STROBE_CYCLES ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### strap_latch.v
// Reset pin synchroniser and strap capture for the shared address pins
`default_nettype none
module strap_latch
(
  input wire core_clk,
  input wire rst,
  input wire chip_reset_n,
  input wire [2:0] strap_pins,
  output reg in_reset_ff,
  output reg [2:0] strap_ff
);

// ==================================================
// Synchronisers
reg rst_n_meta_ff;
reg rst_n_sync_ff;
reg [2:0] pin_meta_ff;
reg [2:0] pin_sync_ff;

always @(posedge core_clk)
begin
  rst_n_meta_ff <= chip_reset_n;
  rst_n_sync_ff <= rst_n_meta_ff;
  pin_meta_ff <= strap_pins;
  pin_sync_ff <= pin_meta_ff;
end

// ==================================================
// Capture
// Sample follows the pins through reset; last sample before release stays
always @(posedge core_clk)
begin
  if (rst)
  begin
    in_reset_ff <= 1'b1;
    strap_ff <= 3'h0;
  end
  else
  begin
    in_reset_ff <= ~rst_n_sync_ff;
    if (~rst_n_sync_ff)
      strap_ff <= pin_sync_ff;
    // Held after release, pin activity ignored
  end
end

endmodule // strap_latch
`default_nettype wire

// ### code_mem_pins.v
// Shared strap / code memory pin block with APB registers
//
// Chosen here: the APB register port and the register offsets.
`include "code_mem_pins_regs.vh"
`default_nettype none
module code_mem_pins
#(
  parameter STROBE_CYC = `STROBE_CYCLES
)
(
  input wire core_clk,
  input wire rst,
  input wire chip_reset_n,
  input wire interrupt_two,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cpu_req,
  input wire cpu_we,
  input wire [15:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  output reg cpu_ack,
  output reg cpu_err,
  output reg [7:0] cpu_rdata,
  input wire code_addr_bit_two_in,
  output reg code_addr_bit_two_out,
  output reg code_addr_bit_two_oe,
  output reg code_addr_bit_two_pd_en,
  input wire [1:0] code_addr_low_pair_in,
  output reg [1:0] code_addr_low_pair_out,
  output reg [1:0] code_addr_low_pair_oe,
  output reg [1:0] code_addr_low_pair_pd_en,
  output reg [12:0] code_addr_upper,
  input wire [7:0] code_data_bus_in,
  output reg [7:0] code_data_bus_out,
  output reg code_data_bus_oe,
  output reg code_mem_write_strobe_n,
  output reg code_mem_read_strobe_n,
  output reg code_mem_chip_enable_n,
  output reg ext_clock_mode,
  output reg ext_clock_48m
);

// ==================================================
// States
localparam ST_IDLE = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_STROBE = 2'h2;
localparam ST_HOLD = 2'h3;

// ==================================================
// Strap capture
wire in_reset_ff;
wire [2:0] strap_ff;

strap_latch strap_latch_inst
(
  .core_clk(core_clk),
  .rst(rst),
  .chip_reset_n(chip_reset_n),
  .strap_pins({code_addr_bit_two_in, code_addr_low_pair_in}),
  .in_reset_ff(in_reset_ff),
  .strap_ff(strap_ff)
);

wire clock_source_strap = strap_ff[2];
wire [1:0] freq_strap = strap_ff[1:0];

// ==================================================
// Control state
reg [2:0] ctrl_ff;
reg [2:0] nxt_ctrl;
reg [1:0] state_ff;
reg [1:0] nxt_state;
reg [7:0] cnt_ff;
reg [7:0] nxt_cnt;
reg we_ff;
reg [7:0] data_meta_ff;
reg [7:0] data_sync_ff;
reg interrupt_two_meta_ff;
reg interrupt_two_sync_ff;

wire idle_bit = ctrl_ff[`CTRL_IDLE_BIT];
wire sleep_bit = ctrl_ff[`CTRL_SLEEP_BIT];
wire internal_code_select = ctrl_ff[`CTRL_INT_CODE_BIT];

// Float condition shared by all three strap pins
wire sleep_cond = idle_bit & ~interrupt_two_sync_ff & sleep_bit;

wire apb_wr = psel & penable & pready & pwrite;
wire apb_setup = psel & ~penable;
wire busy = (state_ff != ST_IDLE);

// ==================================================
// Functions
function addr_ok;
  input [7:0] a;
  begin
    addr_ok = (a == `CTRL_REG_OFFSET) || (a == `STATUS_REG_OFFSET) ||
      (a == `STRAP_REG_OFFSET);
  end
endfunction

// Pin floats in reset, or if its strap was high and the sleep condition holds
function pin_oe;
  input strap_bit;
  input rst_now;
  input cond;
  begin
    pin_oe = ~rst_now & ~(strap_bit & cond);
  end
endfunction

// ==================================================
// Input synchronisers
// Data bus sampled two cycles late; strobe length covers that lag
always @(posedge core_clk)
begin
  data_meta_ff <= code_data_bus_in;
  data_sync_ff <= data_meta_ff;
  interrupt_two_meta_ff <= interrupt_two;
  interrupt_two_sync_ff <= interrupt_two_meta_ff;
end

// ==================================================
// Control register next value
always @*
begin
  nxt_ctrl = ctrl_ff;
  // Interrupt wakes the core; software set in same cycle wins
  if (interrupt_two_sync_ff)
    nxt_ctrl[`CTRL_IDLE_BIT] = 1'b0;
  if (apb_wr && paddr == `CTRL_REG_OFFSET)
    nxt_ctrl = pwdata[2:0];
end

// ==================================================
// APB slave
always @(posedge core_clk)
begin
  if (rst)
  begin
    ctrl_ff <= `CTRL_RESET_VALUE;
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= 32'h0;
  end
  else
  begin
    ctrl_ff <= nxt_ctrl;
    // No wait state: pready rises in the first access cycle
    pready <= apb_setup;
    pslverr <= apb_setup & ~addr_ok(paddr);
    if (apb_setup && !pwrite)
    begin
      case (paddr)
        `CTRL_REG_OFFSET: prdata <= {29'h0, ctrl_ff};
        `STATUS_REG_OFFSET: prdata <= {29'h0, busy, sleep_cond, in_reset_ff};
        `STRAP_REG_OFFSET: prdata <= {26'h0, (freq_strap == 2'h1 || freq_strap == 2'h2),
          clock_source_strap & (freq_strap == `FREQ_48M), clock_source_strap, freq_strap,
          clock_source_strap};
        default: prdata <= 32'h0;
      endcase
    end
  end
end

// ==================================================
// Clock mode decode
// Reserved frequency pairs are flagged, mode falls back to 24MHz
always @(posedge core_clk)
begin
  if (rst)
  begin
    ext_clock_mode <= 1'b0;
    ext_clock_48m <= 1'b0;
  end
  else
  begin
    ext_clock_mode <= clock_source_strap;
    ext_clock_48m <= clock_source_strap & (freq_strap == `FREQ_48M);
  end
end

// ==================================================
// Memory cycle sequencer
always @*
begin
  nxt_state = state_ff;
  nxt_cnt = cnt_ff;
  case (state_ff)
    ST_IDLE:
    begin
      // Request may still stand in the ack cycle, so no new take then
      if (cpu_req && !cpu_ack && !in_reset_ff && !internal_code_select && !sleep_cond)
        nxt_state = ST_SETUP;
    end
    ST_SETUP:
    begin
      nxt_state = ST_STROBE;
      nxt_cnt = STROBE_CYC[7:0];
    end
    ST_STROBE:
    begin
      nxt_cnt = cnt_ff - 8'h01;
      if (cnt_ff == 8'h01)
        nxt_state = ST_HOLD;
    end
    ST_HOLD:
    begin
      nxt_state = ST_IDLE;
    end
    default:
    begin
      nxt_state = ST_IDLE;
    end
  endcase
  if (in_reset_ff)
    nxt_state = ST_IDLE;
end

always @(posedge core_clk)
begin
  if (rst)
  begin
    state_ff <= ST_IDLE;
    cnt_ff <= 8'h0;
    we_ff <= 1'b0;
    cpu_ack <= 1'b0;
    cpu_err <= 1'b0;
    cpu_rdata <= 8'h0;
    code_addr_upper <= 13'h0;
    code_addr_bit_two_out <= 1'b0;
    code_addr_low_pair_out <= 2'h0;
    code_data_bus_out <= 8'h0;
    code_data_bus_oe <= 1'b0;
    code_mem_write_strobe_n <= 1'b1;
    code_mem_read_strobe_n <= 1'b1;
    code_mem_chip_enable_n <= 1'b1;
  end
  else
  begin
    state_ff <= nxt_state;
    cnt_ff <= nxt_cnt;
    cpu_ack <= 1'b0;
    cpu_err <= 1'b0;
    if (state_ff == ST_IDLE && cpu_req && !cpu_ack)
    begin
      if (nxt_state == ST_SETUP)
      begin
        we_ff <= cpu_we;
        code_addr_upper <= cpu_addr[15:3];
        code_addr_bit_two_out <= cpu_addr[2];
        code_addr_low_pair_out <= cpu_addr[1:0];
        code_data_bus_out <= cpu_wdata;
      end
      else
      begin
        // Internal code, reset or sleep: refuse at once
        cpu_ack <= 1'b1;
        cpu_err <= 1'b1;
      end
    end
    // Data bus driven only for an external write
    code_data_bus_oe <= (nxt_state != ST_IDLE) & we_ff & (state_ff != ST_IDLE) |
      (state_ff == ST_IDLE) & (nxt_state == ST_SETUP) & cpu_we;
    code_mem_write_strobe_n <= ~((nxt_state == ST_STROBE) & we_ff);
    code_mem_read_strobe_n <= ~((nxt_state == ST_STROBE) & ~we_ff);
    if (in_reset_ff)
      code_mem_chip_enable_n <= 1'b1;
    else
      code_mem_chip_enable_n <= sleep_cond | internal_code_select;
    if (state_ff == ST_HOLD)
    begin
      cpu_ack <= 1'b1;
      cpu_rdata <= we_ff ? 8'h0 : data_sync_ff;
    end
  end
end

// ==================================================
// Strap pin direction and pull-downs
always @(posedge core_clk)
begin
  if (rst)
  begin
    code_addr_bit_two_oe <= 1'b0;
    code_addr_low_pair_oe <= 2'h0;
    code_addr_bit_two_pd_en <= 1'b1;
    code_addr_low_pair_pd_en <= 2'h3;
  end
  else
  begin
    // Pins listen with pull-downs while reset holds
    code_addr_bit_two_pd_en <= in_reset_ff;
    code_addr_low_pair_pd_en <= {2{in_reset_ff}};
    code_addr_bit_two_oe <= pin_oe(clock_source_strap, in_reset_ff, sleep_cond);
    code_addr_low_pair_oe[1] <= pin_oe(freq_strap[1], in_reset_ff, sleep_cond);
    code_addr_low_pair_oe[0] <= pin_oe(freq_strap[0], in_reset_ff, sleep_cond);
  end
end

endmodule // code_mem_pins
`default_nettype wire

// ### code_mem_pins_chk.sv
// Assertion checker for the shared strap and code memory pins
`default_nettype none
module code_mem_pins_chk
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_reset_n,
  input wire logic cpu_req,
  input wire logic cpu_ack,
  input wire logic code_addr_bit_two_oe,
  input wire logic code_addr_bit_two_pd_en,
  input wire logic [1:0] code_addr_low_pair_oe,
  input wire logic [1:0] code_addr_low_pair_pd_en,
  input wire logic code_mem_write_strobe_n,
  input wire logic code_mem_read_strobe_n,
  input wire logic code_mem_chip_enable_n,
  input wire logic code_data_bus_oe,
  input wire logic ext_clock_mode,
  input wire logic ext_clock_48m
);
  // ==========================================
  // Pin and strobe properties
  // Eight samples cover the pin synchroniser and two register stages
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic [2:0] pd3 = {code_addr_bit_two_pd_en, code_addr_low_pair_pd_en};
  wire logic [2:0] oe3 = {code_addr_bit_two_oe, code_addr_low_pair_oe};
  pull_down_a: assert property (!chip_reset_n [*8] |-> pd3 == 3'h7)
    else $error("pull-downs off while in reset");
  pins_float_a: assert property (!chip_reset_n [*8] |-> oe3 == 3'h0)
    else $error("pins driven while in reset");
  ce_high_a: assert property (!chip_reset_n [*8] |-> code_mem_chip_enable_n)
    else $error("chip enable low while in reset");
  pd_release_a: assert property (chip_reset_n [*8] |-> pd3 == 3'h0)
    else $error("pull-downs left on after release");
  strap_hold_a: assert property (chip_reset_n [*8] |->
    $stable(ext_clock_mode) && $stable(ext_clock_48m))
    else $error("latched strap changed outside reset");
  freq_code_a: assert property (ext_clock_48m |-> ext_clock_mode)
    else $error("48MHz flagged without external clock");
  read_strobe_a: assert property (!code_mem_read_strobe_n |->
    code_mem_write_strobe_n && !code_mem_chip_enable_n)
    else $error("read strobe without chip enable");
  read_bus_free_a: assert property (!code_mem_read_strobe_n |-> !code_data_bus_oe)
    else $error("data bus driven during read");
  ack_pulse_a: assert property (cpu_ack |=> !cpu_ack)
    else $error("acknowledge longer than one cycle");
  write_strobe_a: assert property (!code_mem_write_strobe_n |-> !code_mem_chip_enable_n)
    else $error("write strobe without chip enable");
  req_answer_a: assert property ($rose(cpu_req) |-> ##[1:12] cpu_ack)
    else $error("code memory request not answered");
endmodule // code_mem_pins_chk
bind code_mem_pins code_mem_pins_chk code_mem_pins_chk_inst (.core_clk, .rst, .chip_reset_n,
  .cpu_req, .cpu_ack, .code_addr_bit_two_oe, .code_addr_bit_two_pd_en, .code_addr_low_pair_oe,
  .code_addr_low_pair_pd_en, .code_mem_write_strobe_n, .code_mem_read_strobe_n,
  .code_mem_chip_enable_n, .ext_clock_mode, .ext_clock_48m, .code_data_bus_oe);
`default_nettype wire

// ### code_mem_model.sv
// Behavioural external code memory on the far side of the pins
`default_nettype none
module code_mem_model
(
  input wire logic core_clk,
  input wire logic ce_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic tick = 1'h0;
  always @(posedge core_clk) tick <= ~tick;
  // Write lands as the strobe returns high
  always @(posedge wr_n) if (!ce_n) mem[addr] <= din;
  // Released bus wanders, so stale data cannot pass for a read
  assign dout = (!ce_n && !rd_n) ? mem[addr] : {8{tick}} ^ 8'h5a;
endmodule // code_mem_model
`default_nettype wire

// ### tb_code_mem_pins.sv
// Self-checking bench for the shared strap and code memory pins
`default_nettype none
module tb_code_mem_pins;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0, rst = 1'h1, chip_reset_n = 1'h0, interrupt_two = 1'h0, tick = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, cpu_req = 1'h0, cpu_we = 1'h0, drv = 1'h0;
  logic [7:0] paddr = '0, cpu_wdata = '0, cpu_rdata, code_data_bus_in, code_data_bus_out, rd8, wd;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] cpu_addr = '0, ca;
  logic [12:0] code_addr_upper;
  logic [2:0] strap = '0, s;
  logic [2:0] tbl [4] = '{3'h0, 3'h7, 3'h5, 3'h1};
  logic pready, pslverr, cpu_ack, cpu_err, code_data_bus_oe, er, ext_clock_mode, ext_clock_48m;
  logic code_mem_write_strobe_n, code_mem_read_strobe_n, code_mem_chip_enable_n;
  wire logic [2:0] oe3, out3, pd3;
  int err_count = 0, check_count = 0, seed = 32'hf3ac;
  // ==========================================
  // Pin levels: design drive, strap drive, pull-down, else wandering
  wire logic [2:0] sd = {3{drv}} & strap;
  wire logic [2:0] pin = oe3 & out3 | ~oe3 & sd | ~oe3 & ~sd & ~pd3 & {3{tick}};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) tick <= ~tick;
  code_mem_pins code_mem_pins_inst (.core_clk, .rst, .chip_reset_n, .interrupt_two, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_req, .cpu_we, .cpu_addr,
    .cpu_wdata, .cpu_ack, .cpu_err, .cpu_rdata, .code_addr_bit_two_in(pin[2]),
    .code_addr_bit_two_out(out3[2]), .code_addr_bit_two_oe(oe3[2]),
    .code_addr_bit_two_pd_en(pd3[2]), .code_addr_low_pair_in(pin[1:0]),
    .code_addr_low_pair_out(out3[1:0]), .code_addr_low_pair_oe(oe3[1:0]),
    .code_addr_low_pair_pd_en(pd3[1:0]), .code_addr_upper, .code_data_bus_in,
    .code_data_bus_out, .code_data_bus_oe, .code_mem_write_strobe_n, .code_mem_read_strobe_n,
    .code_mem_chip_enable_n, .ext_clock_mode, .ext_clock_48m);
  code_mem_model code_mem_model_inst (.core_clk, .ce_n(code_mem_chip_enable_n),
    .rd_n(code_mem_read_strobe_n), .wr_n(code_mem_write_strobe_n),
    .addr({code_addr_upper, pin}), .din(code_data_bus_out), .dout(code_data_bus_in));
  // ==========================================
  // Helpers
  function automatic logic [31:0] exp_strap(input logic [2:0] v);
    return {26'h0, ^v[1:0], v == 3'h7, v[2], v[1:0], v[2]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1 && ++n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask
  // Request held until acknowledge is sampled, answer taken at that edge
  task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    cpu_req <= 1'h1;
    cpu_we <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    do @(posedge core_clk); while (cpu_ack !== 1'h1 && ++n < 90);
    if (n >= 90) err_count++;
    rd8 = cpu_rdata;
    er = cpu_err;
    cpu_req <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic results;
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial
  begin
    #200000;
    err_count++;
    results();
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    apb(1'h0, 8'h00, '0);
    chk("ctrl reset", 32'h4, rd);
    apb(1'h1, 8'h0c, 32'h7);
    chk("unmapped err", 32'h1, {31'h0, er});
    for (int i = 0; i < 6; i++)
    begin
      s = i < 4 ? tbl[i] : 3'($random(seed));
      chip_reset_n <= 1'h0;
      strap <= s;
      drv <= 1'h1;
      repeat (10) @(posedge core_clk);
      chk("pd in reset", 32'h7, pd3);
      chk("oe in reset", 32'h0, oe3);
      chk("ce in reset", 32'h1, code_mem_chip_enable_n);
      apb(1'h0, 8'h04, '0);
      chk("status reset", 32'h1, rd);
      chip_reset_n <= 1'h1;
      repeat (8) @(posedge core_clk);
      drv <= 1'h0;
      chk("pd after", 32'h0, pd3);
      chk("oe after", 32'h7, oe3);
      chk("src mode", s[2], ext_clock_mode);
      chk("48m", s == 3'h7, ext_clock_48m);
      apb(1'h0, 8'h08, '0);
      chk("strap reg", exp_strap(s), rd);
      apb(1'h1, 8'h00, 32'h0);
      ca = 16'($random(seed));
      wd = 8'($random(seed));
      cpu(1'h1, ca, wd);
      chk("write err", 32'h0, er);
      cpu(1'h0, ca, 8'h00);
      chk("read data", wd, rd8);
      chk("addr pins", ca, {code_addr_upper, pin});
      apb(1'h1, 8'h00, 32'h3);
      repeat (4) @(posedge core_clk);
      chk("sleep oe", 3'(~s), oe3);
      apb(1'h0, 8'h04, '0);
      chk("status sleep", 32'h2, rd);
      cpu(1'h0, ca, 8'h00);
      chk("sleep refuse", 32'h1, er);
      interrupt_two <= 1'h1;
      repeat (4) @(posedge core_clk);
      chk("wake oe", 32'h7, oe3);
      apb(1'h0, 8'h00, '0);
      chk("idle cleared", 32'h2, rd);
      interrupt_two <= 1'h0;
      apb(1'h1, 8'h00, 32'h4);
      cpu(1'h0, ca, 8'h00);
      chk("internal refuse", 32'h1, er);
    end
    results();
  end
endmodule // tb_code_mem_pins
`default_nettype wire
